// *** empc_pkg.sv ***
// Purpose: constants and types for the external memory pin control block
// Assumes: single 20 MHz clock, synchronous active-high reset
// Notes: strobes are active low at the pins
// Summary of operation
// - host asks for the bus with hold request; device answers with acknowledge
// - bus request output shows device needs the memory bus while hold is acknowledged
// - clock source strap caught on the first cycle after reset release: external, cpu/4, cpu/6; external default
// - divided clock is selected clock divided by one, two or four
// - full rate clock runs at the selected clock rate
// - first strobe: async read, sdram column strobe, sync address strobe or read enable
// - read enable select: zero gives address strobe, one gives read enable
// - second strobe: async output enable, sdram row strobe, sync output enable
// - third strobe: write enable for async, sdram and sync memory
// - sdram clock enable drives self refresh entry and exit
// - without sdram the clock enable pin is a general purpose output
// - dedicated output enable for sync memory reads of space three, for glueless fifo
// - async ready input sampled to finish async access
// - space enables from word address bits 28 to 31, only one asserted
// - byte enables from low address bits, width dependent, also sdram masks
package empc_pkg;
  // -------------------------------------------------
  // clock selection and division
  // -------------------------------------------------
  localparam logic [1:0] EMPC_SRC_EXT = 2'h0;
  localparam logic [1:0] EMPC_SRC_CPU4 = 2'h1;
  localparam logic [1:0] EMPC_SRC_CPU6 = 2'h2;
  localparam logic [1:0] EMPC_DIV_1 = 2'h0;
  localparam logic [1:0] EMPC_DIV_2 = 2'h1;
  localparam logic [1:0] EMPC_DIV_4 = 2'h2;
  localparam logic [2:0] EMPC_CPU4_HALF = 3'h1;
  localparam logic [2:0] EMPC_CPU6_HALF = 3'h2;
  // -------------------------------------------------
  // space types, address fields, widths
  // -------------------------------------------------
  localparam logic [1:0] EMPC_MT_ASYNC = 2'h0;
  localparam logic [1:0] EMPC_MT_SDRAM = 2'h1;
  localparam logic [1:0] EMPC_MT_SYNC = 2'h2;
  localparam int EMPC_SPACE_LO = 28;
  localparam int EMPC_SPACE_HI = 31;
  localparam logic [3:0] EMPC_SPACE3 = 4'h3;
  localparam logic [1:0] EMPC_W8 = 2'h0;
  localparam logic [1:0] EMPC_W16 = 2'h1;
  localparam logic [1:0] EMPC_W32 = 2'h2;
  localparam logic [1:0] EMPC_W64 = 2'h3;
  localparam logic [7:0] EMPC_BE_NONE = 8'hFF;
  localparam logic [3:0] EMPC_CE_NONE = 4'hF;
  // number of decoded spaces, low address field top bit, all lanes on
  localparam logic [3:0] EMPC_SPACE_COUNT = 4'h4;
  localparam int EMPC_LOW_HI = 2;
  localparam logic [7:0] EMPC_BE_ALL = 8'h00;
  // strobe active window length in cycles
  localparam logic [3:0] EMPC_STROBE_CYC = 4'h2;
  // access states, gray coded along the usual path
  typedef enum logic [2:0] {
    EMPC_IDLE = 3'h0,
    EMPC_SETUP = 3'h1,
    EMPC_STROBE = 3'h3,
    EMPC_DONE = 3'h2,
    EMPC_HOLD = 3'h6
  } empc_state_type;
endpackage

// *** empc_pin_ctrl.sv ***
// Purpose: pin-level control of the 64-bit external memory port
// Assumes: inputs synchronous to clock; cpu clock is clock itself
// Notes: clock outputs are made by toggling flops, not a second domain
module empc_pin_ctrl
  import empc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // straps and config
  input wire logic [1:0] clockSourceStrapPins,
  input wire logic [1:0] divSel,
  input wire logic sdramPresent,
  input wire logic gpOutValue,
  input wire logic readEnableSelect,
  input wire logic [1:0] memWidth,
  // access request from the core
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [1:0] reqMemType,
  input wire logic [31:0] reqWordAddr,
  input wire logic selfRefreshReq,
  input wire logic extIfClockIn,
  output logic reqReady,
  output logic reqDone,
  // arbitration pins
  input wire logic holdRequestIn,
  output logic holdAcknowledgeOut,
  output logic busRequestOut,
  // clocks out
  output logic fullRateClockOut,
  output logic dividedClockOut,
  // strobes, active low
  output logic strobeRdCasAdsN,
  output logic strobeOeRasN,
  output logic strobeWeN,
  output logic sdramClockEnable,
  output logic fifoSpaceOutputEnableN,
  input wire logic asyncReadyIn,
  output logic [3:0] spaceEnableN,
  output logic [7:0] byteEnableN,
  output logic pinsDriveEn
);
  empc_state_type state_q;
  logic [1:0] clkSrc_q;
  logic strapDone_q;
  logic [2:0] cpuDiv_q;
  logic cpuClk_q;
  logic extSample_q;
  logic srcClk;
  logic srcRise;
  logic [1:0] div_q;
  logic divClk_q;
  logic fullClk_q;
  logic [3:0] cnt_q;
  logic write_q;
  logic [1:0] mt_q;
  logic [3:0] space_q;
  logic [2:0] lowAddr_q;
  logic [1:0] width_q;
  logic selfRef_q;
  logic rdStrobe;
  logic busy;

  // one-hot low enable from the space field
  function automatic logic [3:0] spaceDecode(input logic [3:0] sp);
    logic [3:0] r;
    r = EMPC_CE_NONE;
    if (sp < EMPC_SPACE_COUNT) begin
      r[sp[1:0]] = 1'b0;
    end
    return r;
  endfunction

  // -------------------------------------------------
  // clock source and output clocks
  // -------------------------------------------------
  // strap capture
  // caught once after release, not under reset, to keep reset constant-only
  always_ff @(posedge clock) begin
    if (srst) begin
      strapDone_q <= 1'b0;
      clkSrc_q <= EMPC_SRC_EXT;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      clkSrc_q <= (clockSourceStrapPins == EMPC_SRC_CPU4 || clockSourceStrapPins == EMPC_SRC_CPU6) ?
                  clockSourceStrapPins : EMPC_SRC_EXT;
    end
  end

  // cpu/4 and cpu/6 generator
  always_ff @(posedge clock) begin
    if (srst) begin
      cpuDiv_q <= 3'h0;
      cpuClk_q <= 1'b0;
    end else if (cpuDiv_q == ((clkSrc_q == EMPC_SRC_CPU6) ? EMPC_CPU6_HALF : EMPC_CPU4_HALF)) begin
      cpuDiv_q <= 3'h0;
      cpuClk_q <= ~cpuClk_q;
    end else begin
      cpuDiv_q <= cpuDiv_q + 3'h1;
    end
  end

  // sampled level of the selected source clock
  always_ff @(posedge clock) begin
    if (srst) begin
      extSample_q <= 1'b0;
    end else begin
      extSample_q <= srcClk;
    end
  end

  assign srcClk = (clkSrc_q == EMPC_SRC_EXT) ? extIfClockIn : cpuClk_q;
  assign srcRise = srcClk & ~extSample_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      fullClk_q <= 1'b0;
      div_q <= 2'h0;
      divClk_q <= 1'b0;
    end else begin
      fullClk_q <= srcClk;
      if (srcRise) begin
        div_q <= div_q + 2'h1;
      end
      case (divSel)
        EMPC_DIV_2: divClk_q <= div_q[0];
        EMPC_DIV_4: divClk_q <= div_q[1];
        default: divClk_q <= srcClk;
      endcase
    end
  end
  assign fullRateClockOut = fullClk_q;
  assign dividedClockOut = divClk_q;

  // -------------------------------------------------
  // access sequencer and arbitration
  // -------------------------------------------------
  // hold after access completes
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= EMPC_IDLE;
      cnt_q <= 4'h0;
      write_q <= 1'b0;
      mt_q <= EMPC_MT_ASYNC;
      space_q <= EMPC_CE_NONE;
      lowAddr_q <= 3'h0;
      width_q <= EMPC_W64;
    end else begin
      case (state_q)
        EMPC_IDLE: begin
          if (holdRequestIn) begin
            state_q <= EMPC_HOLD;
          end else if (reqValid) begin
            state_q <= EMPC_SETUP;
            write_q <= reqWrite;
            mt_q <= reqMemType;
            space_q <= reqWordAddr[EMPC_SPACE_HI:EMPC_SPACE_LO];
            lowAddr_q <= reqWordAddr[EMPC_LOW_HI:0];
            width_q <= memWidth;
          end
        end
        EMPC_SETUP: begin
          state_q <= EMPC_STROBE;
          cnt_q <= 4'h0;
        end
        EMPC_STROBE: begin
          if (cnt_q < EMPC_STROBE_CYC - 4'h1) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (mt_q != EMPC_MT_ASYNC || asyncReadyIn) begin
            state_q <= EMPC_DONE;
          end
        end
        EMPC_DONE: state_q <= EMPC_IDLE;
        EMPC_HOLD: begin
          if (!holdRequestIn) begin
            state_q <= EMPC_IDLE;
          end
        end
        default: state_q <= EMPC_IDLE;
      endcase
    end
  end

  assign holdAcknowledgeOut = (state_q == EMPC_HOLD);
  assign pinsDriveEn = (state_q != EMPC_HOLD);
  assign busy = (state_q == EMPC_SETUP) || (state_q == EMPC_STROBE) || (state_q == EMPC_DONE);
  assign busRequestOut = holdAcknowledgeOut & reqValid;
  assign reqReady = (state_q == EMPC_IDLE) && !holdRequestIn;
  assign reqDone = (state_q == EMPC_DONE);

  // -------------------------------------------------
  // shared strobes
  // -------------------------------------------------
  assign rdStrobe = (state_q == EMPC_STROBE) && !write_q;
  always_comb begin
    strobeRdCasAdsN = 1'b1;
    if (mt_q == EMPC_MT_SYNC && !readEnableSelect) begin
      strobeRdCasAdsN = !(state_q == EMPC_SETUP);
    end else if (mt_q == EMPC_MT_SDRAM) begin
      strobeRdCasAdsN = !(state_q == EMPC_STROBE);
    end else begin
      strobeRdCasAdsN = !rdStrobe;
    end
  end
  assign strobeOeRasN = (mt_q == EMPC_MT_SDRAM) ? !(state_q == EMPC_SETUP) : !rdStrobe;
  assign strobeWeN = !((state_q == EMPC_STROBE) && write_q);
  assign fifoSpaceOutputEnableN = !(rdStrobe && mt_q == EMPC_MT_SYNC && space_q == EMPC_SPACE3);

  always_ff @(posedge clock) begin
    if (srst) begin
      selfRef_q <= 1'b0;
    end else begin
      selfRef_q <= selfRefreshReq;
    end
  end
  assign sdramClockEnable = sdramPresent ? !selfRef_q : gpOutValue;

  assign spaceEnableN = busy ? spaceDecode(space_q) : EMPC_CE_NONE;

  always_comb begin
    byteEnableN = EMPC_BE_NONE;
    if (busy) begin
      case (width_q)
        EMPC_W8: byteEnableN[lowAddr_q] = 1'b0;
        EMPC_W16: byteEnableN[{lowAddr_q[2:1], 1'b0} +: 2] = 2'h0;
        EMPC_W32: byteEnableN[{lowAddr_q[2], 2'h0} +: 4] = 4'h0;
        default: byteEnableN = EMPC_BE_ALL;
      endcase
    end
  end

  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  property p_holdAfterReq;
    @(posedge clock) disable iff (srst) (holdRequestIn && state_q == EMPC_IDLE) |=> holdAcknowledgeOut;
  endproperty
  a_holdAfterReq: assert property (p_holdAfterReq) else $error("hold not acknowledged");
  property p_holdFloat;
    @(posedge clock) disable iff (srst) holdAcknowledgeOut |-> !pinsDriveEn && !busy;
  endproperty
  a_holdFloat: assert property (p_holdFloat) else $error("pins driven during hold");
  property p_holdRelease;
    @(posedge clock) disable iff (srst) (holdAcknowledgeOut && !holdRequestIn) |=> !holdAcknowledgeOut;
  endproperty
  a_holdRelease: assert property (p_holdRelease) else $error("hold not released");
  property p_busReq;
    @(posedge clock) disable iff (srst) busRequestOut |-> holdAcknowledgeOut;
  endproperty
  a_busReq: assert property (p_busReq) else $error("bus request without hold");
  property p_oneSpace;
    @(posedge clock) disable iff (srst) $countones(~spaceEnableN) <= 1;
  endproperty
  a_oneSpace: assert property (p_oneSpace) else $error("several space enables");
  property p_asyncWait;
    @(posedge clock) disable iff (srst)
      (state_q == EMPC_STROBE && mt_q == EMPC_MT_ASYNC && cnt_q != 4'h0 && !asyncReadyIn) |=> state_q == EMPC_STROBE;
  endproperty
  a_asyncWait: assert property (p_asyncWait) else $error("async ended without ready");
  property p_weWrite;
    @(posedge clock) disable iff (srst) !strobeWeN |-> write_q && state_q == EMPC_STROBE;
  endproperty
  a_weWrite: assert property (p_weWrite) else $error("write strobe on read");
  property p_ads;
    @(posedge clock) disable iff (srst)
      (state_q == EMPC_SETUP && mt_q == EMPC_MT_SYNC && !readEnableSelect) |-> !strobeRdCasAdsN;
  endproperty
  a_ads: assert property (p_ads) else $error("address strobe missing");
  property p_cke;
    @(posedge clock) disable iff (srst) sdramPresent && $past(selfRefreshReq) && !$past(srst) |-> !sdramClockEnable;
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable high in self refresh");
  property p_fifo;
    @(posedge clock) disable iff (srst) !fifoSpaceOutputEnableN |-> space_q == EMPC_SPACE3 && !strobeOeRasN;
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo enable off space three");
  c_hold: cover property (@(posedge clock) disable iff (srst) holdAcknowledgeOut ##1 !holdAcknowledgeOut);
  c_write: cover property (@(posedge clock) disable iff (srst) !strobeWeN ##[1:4] reqDone);
  c_asyncWait: cover property (@(posedge clock) disable iff (srst) state_q == EMPC_STROBE && !asyncReadyIn [*3]);
endmodule

// *** empc_far_model.sv ***
// Purpose: far side of the pin block, async memory ready and a bus sharing host
// Assumes: one clock shared with the pin control block
// Notes: ready rests high through its pull-up while no strobe is low
module empc_far_model
  import empc_pkg::*;
(
  // clock and bench control
  input wire logic clock,
  input wire logic [2:0] readyWait,
  input wire logic hostWant,
  // pins from the block
  input wire logic strobeRdCasAdsN,
  input wire logic strobeWeN,
  input wire logic holdAcknowledgeOut,
  // pins to the block
  output logic asyncReadyIn,
  output logic holdRequestIn,
  output logic extIfClockIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] waitCnt = 3'h0;
  logic [1:0] extDiv = 2'h0;
  initial holdRequestIn = 1'b0;
  // slow ready
  // memory holds ready low for readyWait cycles of each strobe
  always @(posedge clock) begin
    if (!strobeRdCasAdsN || !strobeWeN) waitCnt <= (waitCnt == 3'h7) ? waitCnt : waitCnt + 3'h1;
    else waitCnt <= 3'h0;
  end
  assign asyncReadyIn = (strobeRdCasAdsN && strobeWeN) ? 1'b1 : (waitCnt >= readyWait);
  // host handshake
  // host keeps asking until acknowledged, then lets go when done
  always @(posedge clock) begin
    if (hostWant) holdRequestIn <= 1'b1;
    else if (holdAcknowledgeOut) holdRequestIn <= 1'b0;
  end
  // external clock, period of four cycles
  always @(posedge clock) extDiv <= extDiv + 2'h1;
  assign extIfClockIn = extDiv[1];
endmodule

// *** empc_pin_ctrl_tb.sv ***
// Purpose: self-checking bench of the external memory pin control block
// Assumes: far side model drives ready, hold request and external clock
// Notes: outputs sampled on falling edges, inputs driven on rising edges
module empc_pin_ctrl_tb
  import empc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, srst = 1, sdramPresent = 0, gpOutValue = 0, readEnableSelect = 0;
  logic reqValid = 0, reqWrite = 0, selfRefreshReq = 0, hostWant = 0;
  logic [1:0] strap = EMPC_SRC_EXT, divSel = 0, memWidth = 0, reqMemType = 0;
  logic [31:0] reqWordAddr = 0, seed = 32'h00007838, r, a;
  logic [2:0] readyWait = 3'h1;
  wire logic asyncReadyIn, holdRequestIn, extIfClockIn, reqReady, reqDone, holdAcknowledgeOut;
  wire logic busRequestOut, fullRateClockOut, dividedClockOut, strobeRdCasAdsN, strobeOeRasN;
  wire logic strobeWeN, sdramClockEnable, fifoSpaceOutputEnableN, pinsDriveEn;
  wire logic [3:0] spaceEnableN;
  wire logic [7:0] byteEnableN;
  int numErrors = 0, checked = 0, n, t1, t2;
  always #25 clock = ~clock;
  empc_pin_ctrl dut (.clock(clock), .srst(srst), .clockSourceStrapPins(strap), .divSel(divSel),
    .sdramPresent(sdramPresent), .gpOutValue(gpOutValue), .readEnableSelect(readEnableSelect),
    .memWidth(memWidth), .reqValid(reqValid), .reqWrite(reqWrite), .reqMemType(reqMemType),
    .reqWordAddr(reqWordAddr), .selfRefreshReq(selfRefreshReq), .extIfClockIn(extIfClockIn),
    .reqReady(reqReady), .reqDone(reqDone), .holdRequestIn(holdRequestIn),
    .holdAcknowledgeOut(holdAcknowledgeOut), .busRequestOut(busRequestOut),
    .fullRateClockOut(fullRateClockOut), .dividedClockOut(dividedClockOut),
    .strobeRdCasAdsN(strobeRdCasAdsN), .strobeOeRasN(strobeOeRasN), .strobeWeN(strobeWeN),
    .sdramClockEnable(sdramClockEnable), .fifoSpaceOutputEnableN(fifoSpaceOutputEnableN),
    .asyncReadyIn(asyncReadyIn), .spaceEnableN(spaceEnableN), .byteEnableN(byteEnableN),
    .pinsDriveEn(pinsDriveEn));
  empc_far_model far (.clock(clock), .readyWait(readyWait), .hostWant(hostWant),
    .strobeRdCasAdsN(strobeRdCasAdsN), .strobeWeN(strobeWeN),
    .holdAcknowledgeOut(holdAcknowledgeOut), .asyncReadyIn(asyncReadyIn),
    .holdRequestIn(holdRequestIn), .extIfClockIn(extIfClockIn));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // byte lane low per width, wider memories use fewer address bits
  function automatic logic [7:0] be_exp(logic [1:0] w, logic [31:0] ad);
    case (w)
      EMPC_W8: return ~(8'h01 << ad[2:0]);
      EMPC_W16: return ~(8'h03 << {ad[2:1], 1'b0});
      EMPC_W32: return ~(8'h0F << {ad[2], 2'b00});
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [3:0] ce_exp(logic [31:0] ad);
    return (ad[31:28] < 4'h4) ? ~(4'h1 << ad[29:28]) : EMPC_CE_NONE;
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic giveVerdict();
    if (numErrors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one access, walked cycle by cycle from the take edge
  task automatic access(logic [1:0] mt, logic wr, logic [31:0] ad, logic [1:0] w, logic [3:0] rs);
    @(posedge clock);
    reqMemType <= mt;
    reqWrite <= wr;
    reqWordAddr <= ad;
    memWidth <= w;
    readEnableSelect <= rs[0];
    readyWait <= rs[3:1];
    reqValid <= 1'b1;
    n = 0;
    do begin @(negedge clock); n++; end while (reqReady !== 1'b1 && n < 20);
    chk("request taken", 1, reqReady);
    @(posedge clock) reqValid <= 1'b0;
    @(negedge clock);
    chk("row strobe", mt != EMPC_MT_SDRAM, strobeOeRasN);
    chk("address strobe", !(mt == EMPC_MT_SYNC && !rs[0]), strobeRdCasAdsN);
    @(negedge clock);
    chk("space enables", ce_exp(ad), spaceEnableN);
    chk("byte enables", be_exp(w, ad), byteEnableN);
    chk("write strobe", !wr, strobeWeN);
    chk("read strobe", (mt == EMPC_MT_SYNC) ? (!rs[0] || wr) : (wr && mt != EMPC_MT_SDRAM), strobeRdCasAdsN);
    chk("output enable", (mt == EMPC_MT_SDRAM) ? 1'b1 : wr, strobeOeRasN);
    chk("fifo oe", !(!wr && mt == EMPC_MT_SYNC && ad[31:28] == EMPC_SPACE3), fifoSpaceOutputEnableN);
    n = 2;
    while (reqDone !== 1'b1 && n < 20) begin @(negedge clock); n++; end
    // ready is first looked at on the second strobe cycle, so slow memory adds readyWait minus one
    if (mt != EMPC_MT_ASYNC) chk("done cycle", 4, n);
    else chk("async done", (rs[3:1] > 3'h1) ? rs[3:1] + 3 : 4, n);
  endtask
  // count output clock edges over a span of samples
  task automatic count_edges(int span);
    logic pf, pd;
    t1 = 0;
    t2 = 0;
    @(negedge clock);
    pf = fullRateClockOut;
    pd = dividedClockOut;
    repeat (span) begin
      @(negedge clock);
      t1 += (fullRateClockOut !== pf);
      t2 += (dividedClockOut !== pd);
      pf = fullRateClockOut;
      pd = dividedClockOut;
    end
  endtask
  initial begin
    #(50 * 30000);
    numErrors++;
    giveVerdict();
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (7) @(posedge clock);
    @(negedge clock);
    chk("reset pins", 4'h7, {holdAcknowledgeOut, strobeRdCasAdsN, strobeOeRasN, strobeWeN});
    @(posedge clock) srst <= 1'b0;
    access(EMPC_MT_SYNC, 1'b0, 32'h3000_0007, EMPC_W8, 4'h0);
    access(EMPC_MT_SDRAM, 1'b1, 32'hF000_0000, EMPC_W64, 4'h1);
    access(EMPC_MT_ASYNC, 1'b0, 32'h1000_0002, EMPC_W16, 4'hF);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      a = xs();
      access(2'(i % 3), r[0], a, r[2:1], r[6:3]);
    end
    @(posedge clock) hostWant <= 1'b1;
    n = 0;
    do begin @(negedge clock); n++; end while (holdAcknowledgeOut !== 1'b1 && n < 10);
    chk("hold ack delay", 3, n);
    chk("pins floated", 0, pinsDriveEn);
    chk("bus req idle", 0, busRequestOut);
    @(posedge clock) reqValid <= 1'b1;
    @(negedge clock);
    chk("bus req", 1, busRequestOut);
    chk("refused in hold", 0, reqReady);
    @(posedge clock) reqValid <= 1'b0;
    hostWant <= 1'b0;
    n = 0;
    do begin @(negedge clock); n++; end while (holdAcknowledgeOut !== 1'b0 && n < 10);
    chk("hold release", 1, n <= 4);
    for (int d = 0; d < 3; d++) begin
      @(posedge clock) divSel <= 2'(d);
      repeat (4) @(posedge clock);
      count_edges(32);
      chk("full rate edges", 16, t1);
      chk("divided edges", 16 >> d, t2);
    end
    // cpu/4 gives a toggle every two cycles, cpu/6 every three
    for (int s = 1; s < 3; s++) begin
      @(posedge clock) srst <= 1'b1;
      strap <= 2'(s);
      divSel <= EMPC_DIV_1;
      @(posedge clock) srst <= 1'b0;
      repeat (4) @(posedge clock);
      count_edges(48);
      chk("cpu clock edges", (s == 1) ? 24 : 16, t1);
    end
    @(posedge clock) sdramPresent <= 1'b1;
    selfRefreshReq <= 1'b1;
    repeat (2) @(negedge clock);
    chk("cke in refresh", 0, sdramClockEnable);
    @(posedge clock) selfRefreshReq <= 1'b0;
    repeat (2) @(negedge clock);
    chk("cke out of refresh", 1, sdramClockEnable);
    repeat (6) begin
      r = xs();
      @(posedge clock) sdramPresent <= 1'b0;
      gpOutValue <= r[0];
      @(negedge clock);
      chk("general output", r[0], sdramClockEnable);
    end
    giveVerdict();
  end
endmodule
